// *** design/sic_pkg.sv ***
// constants for the self-id status and upper channel enable registers
package sic_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_SELF_ID_STATUS = 8'h68;
   localparam logic [7:0] OFS_UPPER_SET = 8'h70;
   localparam logic [7:0] OFS_UPPER_CLEAR = 8'h74;
   // self-id status field positions
   localparam int FAULT_BIT = 31;
   localparam int GEN_LSB = 16;
   localparam int GEN_MSB = 23;
   localparam int SIZE_LSB = 2;
   localparam int SIZE_MSB = 10;
   localparam int GEN_W = GEN_MSB - GEN_LSB + 1;
   localparam int SIZE_W = SIZE_MSB - SIZE_LSB + 1;
   // reset values
   localparam logic [GEN_W-1:0] GEN_RESET = 8'h00;
   localparam logic [SIZE_W-1:0] SIZE_RESET = 9'h000;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   // first channel number covered by the upper mask
   localparam logic [5:0] UPPER_CHANNEL_BASE = 6'h20;
   // buffer base alignment: 2 kbyte, base held in bits 31..11
   localparam int BASE_LSB = 11;
endpackage : sic_pkg

// *** design/sic_channel_mask.sv ***
// upper isochronous channel enable mask with set and clear write ports
module sic_channel_mask (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // register writes
   input wire logic set_we_in,
   input wire logic clear_we_in,
   input wire logic [31:0] wdata_in,
   // channel lookup
   input wire logic [5:0] channel_in,
   // results
   output logic [31:0] mask_out,
   output logic accept_out
);
   logic [31:0] mask;

   // ones set or clear, zeros leave bits alone
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         mask <= sic_pkg::MASK_RESET;
      end else if (set_we_in) begin
         mask <= mask | wdata_in;
      end else if (clear_we_in) begin
         mask <= mask & ~wdata_in;
      end
   end

   assign mask_out = mask;

   // bit n enables channel 32+n; lower channels never accepted here
   always_comb begin
      if (channel_in >= sic_pkg::UPPER_CHANNEL_BASE) begin
         accept_out = mask[channel_in[4:0]];
      end else begin
         accept_out = 1'b0;
      end
   end
endmodule : sic_channel_mask

// *** design/sic_self_id_status.sv ***
// self-id status register and upper channel enable register bank
module sic_self_id_status (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // host register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_wdata_in,
   output logic [31:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // link events
   input wire logic bus_reset_in,
   input wire logic rx_begin_in,
   input wire logic rx_quadlet_in,
   input wire logic rx_end_in,
   input wire logic rx_hw_error_in,
   input wire logic host_write_error_in,
   // self-id buffer addressing
   input wire logic [31:0] buffer_base_in,
   output logic [31:0] buffer_addr_out,
   // isochronous channel filter
   input wire logic [5:0] iso_channel_in,
   output logic iso_accept_out,
   output logic [31:0] upper_channel_enable_out
);
   logic identity_reception_fault_flag;
   logic [sic_pkg::GEN_W-1:0] bus_reset_generation_count;
   logic [sic_pkg::SIZE_W-1:0] identity_buffer_quadlet_count;
   logic rx_error_seen;
   logic error_now;
   logic set_we;
   logic clear_we;
   logic [31:0] mask;
   logic [31:0] status_word;
   logic [31:0] next_rdata;

   // true when the bus address selects the given register offset; shared
   // by the set and clear write decodes so both compare the same way
   function automatic logic addr_hit(input logic [7:0] addr,
                                     input logic [7:0] ofs);
      addr_hit = (addr == ofs);
   endfunction : addr_hit

   // true when the quadlet count has reached the top of its field; the
   // count holds there rather than wrap and report a tiny buffer
   function automatic logic count_full(
      input logic [sic_pkg::SIZE_W-1:0] count);
      count_full = (count == {sic_pkg::SIZE_W{1'b1}});
   endfunction : count_full

   // both fault sources count as errors
   assign error_now = rx_hw_error_in | host_write_error_in;

   // generation counter, 8-bit natural wrap
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         bus_reset_generation_count <= sic_pkg::GEN_RESET;
      end else if (bus_reset_in) begin
         bus_reset_generation_count <= bus_reset_generation_count
                                       + 8'h01;
      end
   end

   // quadlet count: cleared at start, saturates at field maximum
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         identity_buffer_quadlet_count <= sic_pkg::SIZE_RESET;
      end else if (rx_begin_in) begin
         identity_buffer_quadlet_count <= sic_pkg::SIZE_RESET;
      end else if (rx_quadlet_in &&
                   !count_full(identity_buffer_quadlet_count)) begin
         identity_buffer_quadlet_count <= identity_buffer_quadlet_count
                                          + 9'h001;
      end
   end

   // error seen during the reception in progress
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rx_error_seen <= 1'b0;
      end else if (rx_begin_in) begin
         rx_error_seen <= error_now;
      end else if (rx_end_in) begin
         rx_error_seen <= 1'b0;
      end else if (error_now) begin
         rx_error_seen <= 1'b1;
      end
   end

   // fault flag: an error sets at once; a clean end clears; set wins
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         identity_reception_fault_flag <= 1'b0;
      end else if (error_now) begin
         identity_reception_fault_flag <= 1'b1;
      end else if (rx_end_in && !rx_error_seen) begin
         identity_reception_fault_flag <= 1'b0;
      end
   end

   // next quadlet address: aligned base plus count of quadlets
   assign buffer_addr_out = {buffer_base_in[31:sic_pkg::BASE_LSB],
                             11'h000}
                            + {21'h000000, identity_buffer_quadlet_count,
                               2'b00};

   // write decode for the mask; status is read only
   assign set_we = reg_wr_in &&
                   addr_hit(reg_addr_in, sic_pkg::OFS_UPPER_SET);
   assign clear_we = reg_wr_in &&
                     addr_hit(reg_addr_in, sic_pkg::OFS_UPPER_CLEAR);

   sic_channel_mask u_mask (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .set_we_in(set_we),
      .clear_we_in(clear_we),
      .wdata_in(reg_wdata_in),
      .channel_in(iso_channel_in),
      .mask_out(mask),
      .accept_out(iso_accept_out)
   );

   assign upper_channel_enable_out = mask;

   // status word assembly, reserved bits zero
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[sic_pkg::FAULT_BIT] = identity_reception_fault_flag;
      status_word[sic_pkg::GEN_MSB:sic_pkg::GEN_LSB] =
         bus_reset_generation_count;
      status_word[sic_pkg::SIZE_MSB:sic_pkg::SIZE_LSB] =
         identity_buffer_quadlet_count;
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      unique case (reg_addr_in)
         sic_pkg::OFS_SELF_ID_STATUS: next_rdata = status_word;
         sic_pkg::OFS_UPPER_SET: next_rdata = mask;
         sic_pkg::OFS_UPPER_CLEAR: next_rdata = mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // read strobe echoed one cycle later as the valid pulse
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
      end
   end

   // read data captured on the read edge and held until the next read,
   // so a late host sample still sees the word it asked for
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         reg_rdata_out <= next_rdata;
      end
   end
endmodule : sic_self_id_status

// *** tb/sic_sva.sv ***
// assertions on the self-id status and upper channel enable ports
module sic_sva (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   // link events
   input wire logic rx_begin_in,
   input wire logic rx_quadlet_in,
   input wire logic rx_hw_error_in,
   input wire logic host_write_error_in,
   // buffer address and channel filter
   input wire logic [31:0] buffer_addr_out,
   input wire logic [5:0] iso_channel_in,
   input wire logic iso_accept_out,
   input wire logic [31:0] upper_channel_enable_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   wire logic [31:0] m = upper_channel_enable_out;
   sequence s_fault; rx_hw_error_in || host_write_error_in; endsequence
   sequence s_stat_rd; reg_rd_in && reg_addr_in == 8'h68; endsequence
   sequence s_mask_rd;
      reg_rd_in && (reg_addr_in == 8'h70 || reg_addr_in == 8'h74);
   endsequence
   a_read_pulse: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("no read valid");
   a_set_bits: assert property (reg_wr_in && reg_addr_in == 8'h70
      |=> m == ($past(m) | $past(reg_wdata_in))) else $error("set wrong");
   a_clear_bits: assert property (reg_wr_in && reg_addr_in == 8'h74
      |=> m == ($past(m) & ~$past(reg_wdata_in))) else $error("clr wrong");
   a_mask_read: assert property (s_mask_rd
      |=> reg_rdata_out == $past(m)) else $error("mask read wrong");
   a_stat_zero: assert property (s_stat_rd
      |=> (reg_rdata_out & 32'h7F00_F803) == 32'h0) else $error("unused set");
   a_fault_seen: assert property (s_fault ##[1:2] s_stat_rd
      |=> reg_rdata_out[31]) else $error("fault flag clear");
   a_iso_map: assert property (iso_accept_out
      == (iso_channel_in[5] && m[iso_channel_in[4:0]])) else $error("iso");
   a_quad_step: assert property (rx_quadlet_in && !rx_begin_in
      && buffer_addr_out[10:2] != 9'h1FF
      |=> buffer_addr_out == $past(buffer_addr_out) + 32'h4)
      else $error("quadlet address step wrong");
endmodule : sic_sva

// *** tb/tb_top.sv ***
// testbench for the self-id status and upper channel enable bank
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic reg_rvalid_out, iso_accept_out;
   logic [7:0] reg_addr_in = 8'h00;
   logic [5:0] ev = 6'h00, iso_channel_in = 6'h00;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, buffer_addr_out;
   logic [31:0] upper_channel_enable_out;
   logic [31:0] buf_base = 32'h1234_5FFF;
   logic [63:0] en = {32'h0000_E001, 32'h0};
   logic [71:0] rows [5] = '{{8'h70, 32'h8000_0001, 32'h8000_0001},
      {8'h70, 32'h0000_F000, 32'h8000_F001}, {8'h74, 32'h8000_1000,
      32'h0000_E001}, {8'h74, 32'h0, 32'h0000_E001},
      {8'h70, 32'h0, 32'h0000_E001}};
   int fails = 0, n_compared = 0;
   sic_self_id_status u_sic_self_id_status (.core_clk_in, .rst_in,
      .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
      .reg_rvalid_out, .bus_reset_in(ev[5]), .rx_begin_in(ev[4]),
      .rx_quadlet_in(ev[3]), .rx_end_in(ev[2]), .rx_hw_error_in(ev[1]),
      .host_write_error_in(ev[0]), .buffer_base_in(buf_base),
      .buffer_addr_out, .iso_channel_in, .iso_accept_out,
      .upper_channel_enable_out);
   // clock and shared tasks
   always #25 core_clk_in = ~core_clk_in;
   task automatic chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge core_clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge core_clk_in);
      reg_wr_in = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(negedge core_clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge core_clk_in);
      reg_rd_in = 1'b0;
      chk({31'h0, reg_rvalid_out}, 32'h1);
      chk(reg_rdata_out, exp);
   endtask : rd
   task automatic evp(input logic [5:0] v);
      @(negedge core_clk_in);
      ev = v;
      @(negedge core_clk_in);
      ev = 6'h00;
   endtask : evp
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // main sequence
   initial begin
      repeat (4) @(negedge core_clk_in);
      rst_in = 1'b0;
      rd(8'h68, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i][71:64], rows[i][63:32]);
         rd(rows[i][71:64], rows[i][31:0]);
         chk(upper_channel_enable_out, rows[i][31:0]);
      end
      for (int c = 0; c < 64; c++) begin
         @(negedge core_clk_in);
         iso_channel_in = c[5:0];
         #1 chk({31'h0, iso_accept_out}, {31'h0, en[c]});
      end
      $display("mask tests done");
      wr(8'h68, 32'hFFFF_FFFF);
      rd(8'h68, 32'h0);
      rd(8'h7C, 32'h0);
      evp(6'h10);
      evp(6'h08);
      evp(6'h0A);
      evp(6'h08);
      evp(6'h04);
      rd(8'h68, 32'h8000_000C);
      chk(buffer_addr_out, 32'h1234_580C);
      evp(6'h10);
      evp(6'h08);
      evp(6'h04);
      rd(8'h68, 32'h0000_0004);
      evp(6'h10);
      evp(6'h01);
      rd(8'h68, 32'h8000_0000);
      evp(6'h04);
      repeat (255) evp(6'h20);
      rd(8'h68, 32'h80FF_0000);
      evp(6'h20);
      rd(8'h68, 32'h8000_0000);
      // begin beside a quadlet: begin wins and the count clears from one to zero
      evp(6'h10);
      evp(6'h08);
      evp(6'h18);
      buf_base = 32'hFFFF_FABC;
      rd(8'h68, 32'h8000_0000);
      // a long run of quadlets saturates the count at its field top
      @(negedge core_clk_in);
      ev = 6'h08;
      repeat (515) @(negedge core_clk_in);
      ev = 6'h00;
      evp(6'h04);
      rd(8'h68, 32'h0000_07FC);
      chk(buffer_addr_out, 32'hFFFF_FFFC);
      // an error on the closing edge still raises the flag
      evp(6'h10);
      evp(6'h06);
      rd(8'h68, 32'h8000_0000);
      $display("status tests done");
      // reset in mid-run clears the status and the mask
      @(negedge core_clk_in);
      rst_in = 1'b1;
      repeat (2) @(negedge core_clk_in);
      rst_in = 1'b0;
      chk(upper_channel_enable_out, 32'h0);
      chk({31'h0, reg_rvalid_out}, 32'h0);
      rd(8'h68, 32'h0);
      rd(8'h74, 32'h0);
      $display("reset tests done");
      conclude();
   end
   // watchdog against a hang: the tests need about 1,200 cycles (59 us)
   initial begin
      #200000;
      fails++;
      conclude();
   end
endmodule : tb_top
bind sic_self_id_status sic_sva u_sic_sva (
   .core_clk_in(core_clk_in),
   .rst_in(rst_in),
   .reg_addr_in(reg_addr_in),
   .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in),
   .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out),
   .reg_rvalid_out(reg_rvalid_out),
   .rx_begin_in(rx_begin_in),
   .rx_quadlet_in(rx_quadlet_in),
   .rx_hw_error_in(rx_hw_error_in),
   .host_write_error_in(host_write_error_in),
   .buffer_addr_out(buffer_addr_out),
   .iso_channel_in(iso_channel_in),
   .iso_accept_out(iso_accept_out),
   .upper_channel_enable_out(upper_channel_enable_out)
);
